/* src/tfi_pkg.sv */
// package for the transponder field interface controller: timing figures,
// serial control byte layout, special command codes, states and carriers.
// assumes a single 25 MHz system clock and synchronous pin inputs.
package tfi_pkg;

    // clock rate in MHz, used to turn microsecond figures into cycles
    localparam int CLK_MHZ = 25;

    // battery-to-field switch delay, plain default
    localparam int T_BFS_US = 100;
    localparam int BFS_CYC = T_BFS_US * CLK_MHZ;
    // field loss filter before falling back to battery
    localparam int T_FOFF_US = 20;
    localparam int FOFF_CYC = T_FOFF_US * CLK_MHZ;
    // length of the reset pulse given on field removal
    localparam int T_RST_US = 10;
    localparam int RST_CYC = T_RST_US * CLK_MHZ;
    // half of one coded modulator bit
    localparam int T_HALF_US = 50;
    localparam int HALF_CYC = T_HALF_US * CLK_MHZ;

    // store geometry: 32 rows of 16 bits
    localparam int ROWS = 32;
    localparam int ROW_W = 5;
    localparam int WORD_W = 16;

    // control byte fields
    localparam int CB_ROW_MSB = 7;
    localparam int CB_ROW_LSB = 3;
    localparam int CB_MODE_MSB = 2;
    localparam int CB_MODE_LSB = 1;
    localparam int CB_RNW = 0;

    // mode field values
    localparam logic [1:0] MODE_HI_LO = 2'h0;
    localparam logic [1:0] MODE_LO_HI = 2'h1;
    localparam logic [1:0] MODE_SPECIAL = 2'h3;

    // special commands carried in the row field when mode is special
    localparam logic [4:0] CMD_PM_OFF = 5'h00;
    localparam logic [4:0] CMD_PM_ON = 5'h01;
    localparam logic [4:0] CMD_MOD_MANCH = 5'h02;
    localparam logic [4:0] CMD_MOD_BIPH = 5'h03;

    // serial engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CTRL = 3'b001,
        ST_ACK_C = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK_W = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK = 3'b110,
        ST_WAIT = 3'b111
    } tfi_state_t;

    // the two serial lines as seen at the pins
    typedef struct packed {
        logic scl;
        logic sda;
    } tfi_twi_t;

endpackage

/* src/tfi_ctrl.sv */
// digital control of a contactless transponder front end: supply selection,
// field/gap output, field clock, serial store access and coded modulator.
// assumes all pin inputs are already synchronous to sys_clk and that the
// analog comparator delivers a clean field_detect level.
`timescale 1ns/10ps
`default_nettype none
module tfi_ctrl #(
    parameter int BFS_CYC = tfi_pkg::BFS_CYC,
    parameter int FOFF_CYC = tfi_pkg::FOFF_CYC,
    parameter int RST_CYC = tfi_pkg::RST_CYC,
    parameter int HALF_CYC = tfi_pkg::HALF_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic field_detect,
    input wire logic carrier_in,
    input wire logic damping_control_input,
    input wire tfi_pkg::tfi_twi_t twi_in,
    output logic sda_out,
    output logic sda_oe,
    output logic damping_on,
    output logic energy_max,
    output logic field_present_output,
    output logic field_clk_out,
    output logic supply_field,
    output logic host_reset_n,
    output logic modulator_active
);

    // supply management state
    logic sup_q, sup_d; // field supply selected
    logic auto_q, auto_d; // automatic switching enabled
    logic [11:0] on_cnt_q, on_cnt_d; // field-on low pass
    logic [11:0] off_cnt_q, off_cnt_d; // field-off low pass
    logic [11:0] rst_cnt_q, rst_cnt_d; // host reset pulse length
    logic rstn_q, rstn_d; // registered host reset, low while counting
    logic fp_q, fp_d; // field present output
    logic clk_s1_q, clk_s2_q; // carrier edge synchroniser

    // serial engine state
    tfi_pkg::tfi_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d; // bit counter in a byte
    logic [7:0] sh_q, sh_d; // receive shift register
    logic [4:0] row_q, row_d; // selected row
    logic lohi_q, lohi_d; // byte order: low byte first
    logic second_q, second_d; // next byte is the second of the word
    logic [15:0] wbuf_q, wbuf_d; // write buffer
    logic [1:0] wcnt_q, wcnt_d; // write bytes received
    logic oe_q, oe_d; // sda pulled low
    logic scl_q, sda_q; // previous line samples

    // modulator state
    logic mact_q, mact_d; // modulator engaged
    logic manch_q, manch_d; // manchester when set, bi-phase otherwise
    logic mbit_q, mbit_d; // bit being coded
    logic enc_q, enc_d; // coded level
    logic [11:0] hcnt_q, hcnt_d; // half-bit timer
    logic hrun_q, hrun_d; // half-bit timer running
    logic damp_q, damp_d; // damping stage drive
    logic emax_q, emax_d; // maximum energy routing

    // the store itself; contents survive resets like a nonvolatile array
    logic [tfi_pkg::WORD_W-1:0] mem [tfi_pkg::ROWS];
    logic mem_we;
    logic [15:0] mem_wd;

    // line conditions seen on the serial pins
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [15:0] word;
    logic [7:0] rbyte;
    assign scl_rise = twi_in.scl & ~scl_q;
    assign scl_fall = ~twi_in.scl & scl_q;
    // data changing while scl stays high marks start or stop
    assign start_c = twi_in.scl & scl_q & sda_q & ~twi_in.sda;
    assign stop_c = twi_in.scl & scl_q & ~sda_q & twi_in.sda;
    assign word = mem[row_q];
    // byte order follows the mode bit latched from the control byte
    assign rbyte = (second_q ^ lohi_q) ? word[7:0] : word[15:8];

    // supply selection, field output and host reset
    always_comb begin
        sup_d = sup_q;
        auto_d = auto_d_cmd(auto_q);
        on_cnt_d = 12'h000;
        off_cnt_d = 12'h000;
        rst_cnt_d = (rst_cnt_q != 12'h000) ? rst_cnt_q - 12'h001 : 12'h000;
        if (!auto_d) begin
            // switched off: stay on battery until switch-on or reset
            sup_d = 1'b0;
        end else if (!sup_q && field_detect) begin
            // low pass against interference before taking the field
            on_cnt_d = on_cnt_q + 12'h001;
            if (on_cnt_q == 12'(BFS_CYC - 1)) begin
                sup_d = 1'b1;
            end
        end else if (sup_q && !field_detect) begin
            // short gaps must not drop supply, only a lasting loss
            off_cnt_d = off_cnt_q + 12'h001;
            if (off_cnt_q == 12'(FOFF_CYC - 1)) begin
                sup_d = 1'b0;
                rst_cnt_d = 12'(RST_CYC);
            end
        end
        // with auto mode on, the output stays low until the switch-over,
        // so its first rising edge is the wake-up event
        fp_d = field_detect & (sup_d | ~auto_d);
        // registered so the host never sees a decode glitch
        rstn_d = (rst_cnt_d == 12'h000);
    end

    // special commands only act on the ack of a special control byte
    function automatic logic auto_d_cmd(input logic cur);
        logic r;
        r = cur;
        if (st_q == tfi_pkg::ST_ACK_C && scl_fall &&
            sh_q[tfi_pkg::CB_MODE_MSB:tfi_pkg::CB_MODE_LSB] ==
            tfi_pkg::MODE_SPECIAL) begin
            if (sh_q[tfi_pkg::CB_ROW_MSB:tfi_pkg::CB_ROW_LSB] ==
                tfi_pkg::CMD_PM_OFF) begin
                r = 1'b0;
            end else if (sh_q[tfi_pkg::CB_ROW_MSB:tfi_pkg::CB_ROW_LSB] ==
                tfi_pkg::CMD_PM_ON) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    // serial engine: control byte, store access and command decode
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        row_d = row_q;
        lohi_d = lohi_q;
        second_d = second_q;
        wbuf_d = wbuf_q;
        wcnt_d = wcnt_q;
        oe_d = oe_q;
        mact_d = mact_q;
        manch_d = manch_q;
        mem_we = 1'b0;
        mem_wd = word;
        if (stop_c) begin
            // a stop ends any transfer and commits buffered write bytes
            if (wcnt_q == 2'h2) begin
                mem_we = 1'b1;
                mem_wd = wbuf_q;
            end else if (wcnt_q == 2'h1) begin
                mem_we = 1'b1; // 8-bit write keeps the other byte
                mem_wd = lohi_q ? {word[15:8], wbuf_q[7:0]}
                                : {wbuf_q[15:8], word[7:0]};
            end
            st_d = tfi_pkg::ST_IDLE;
            oe_d = 1'b0;
            wcnt_d = 2'h0;
            mact_d = 1'b0;
        end else if (start_c) begin
            st_d = tfi_pkg::ST_CTRL;
            bit_d = 4'h0;
            oe_d = 1'b0;
            wcnt_d = 2'h0;
            mact_d = 1'b0;
        end else begin
            case (st_q)
                tfi_pkg::ST_CTRL, tfi_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], twi_in.sda};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        oe_d = 1'b1; // acknowledge the byte
                        if (st_q == tfi_pkg::ST_CTRL) begin
                            st_d = tfi_pkg::ST_ACK_C;
                        end else begin
                            st_d = tfi_pkg::ST_ACK_W;
                            wcnt_d = wcnt_q + 2'h1;
                            if ((wcnt_q == 2'h0) ^ lohi_q) begin
                                wbuf_d[15:8] = sh_q;
                            end else begin
                                wbuf_d[7:0] = sh_q;
                            end
                        end
                    end
                end
                tfi_pkg::ST_ACK_C: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        bit_d = 4'h0;
                        row_d = sh_q[tfi_pkg::CB_ROW_MSB:tfi_pkg::CB_ROW_LSB];
                        lohi_d = sh_q[tfi_pkg::CB_MODE_LSB];
                        second_d = 1'b0;
                        if (sh_q[tfi_pkg::CB_MODE_MSB:tfi_pkg::CB_MODE_LSB]
                            == tfi_pkg::MODE_SPECIAL) begin
                            st_d = tfi_pkg::ST_WAIT;
                            if (row_d == tfi_pkg::CMD_MOD_MANCH ||
                                row_d == tfi_pkg::CMD_MOD_BIPH) begin
                                mact_d = 1'b1;
                                manch_d = (row_d == tfi_pkg::CMD_MOD_MANCH);
                            end
                        end else if (sh_q[tfi_pkg::CB_RNW]) begin
                            st_d = tfi_pkg::ST_RDATA;
                            oe_d = ~((lohi_d ? mem[row_d][7] : mem[row_d][15]));
                        end else begin
                            st_d = tfi_pkg::ST_WDATA;
                        end
                    end
                end
                tfi_pkg::ST_ACK_W: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        bit_d = 4'h0;
                        // at most two bytes go into one row
                        st_d = (wcnt_q == 2'h2) ? tfi_pkg::ST_WAIT
                                                : tfi_pkg::ST_WDATA;
                    end
                end
                tfi_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            oe_d = 1'b0; // release for the master's ack
                            st_d = tfi_pkg::ST_RACK;
                        end else begin
                            oe_d = ~rbyte[3'(4'h7 - bit_q)];
                        end
                    end
                end
                tfi_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (twi_in.sda) begin
                            st_d = tfi_pkg::ST_WAIT; // not acknowledged
                        end else begin
                            second_d = ~second_q;
                            row_d = second_q ? row_q + 5'h01 : row_q;
                        end
                    end else if (scl_fall) begin
                        st_d = tfi_pkg::ST_RDATA;
                        bit_d = 4'h0;
                        oe_d = ~rbyte[7];
                    end
                end
                default: begin
                    // idle or waiting for stop: lines are only watched
                end
            endcase
        end
    end

    // modulator coding and damping stage drive
    always_comb begin
        mbit_d = mbit_q;
        enc_d = enc_q;
        hcnt_d = hcnt_q;
        hrun_d = hrun_q;
        if (mact_q && scl_rise) begin
            // each scl rise presents one bit on sda; host paces the bits
            mbit_d = twi_in.sda;
            enc_d = manch_q ? twi_in.sda : ~enc_q;
            hcnt_d = 12'h000;
            hrun_d = 1'b1;
        end else if (hrun_q) begin
            hcnt_d = hcnt_q + 12'h001;
            if (hcnt_q == 12'(HALF_CYC - 1)) begin
                hrun_d = 1'b0;
                // mid-bit: manchester always flips, bi-phase only for zero
                if (manch_q || !mbit_q) begin
                    enc_d = ~enc_q;
                end
            end
        end
        if (!mact_q) begin
            hrun_d = 1'b0;
            enc_d = 1'b0;
        end
        // one damps, zero leaves undamped; the coder wins when engaged
        damp_d = mact_q ? enc_q : damping_control_input;
        // the host keeps this high in reset for best start-up
        emax_d = damping_control_input & sup_q;
    end

    // store write port, no reset so the contents persist
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[row_q] <= mem_wd;
        end
    end

    // register all state but the store; outputs other than sda_out come straight from these flip-flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sup_q <= 1'b0;
            auto_q <= 1'b1;
            on_cnt_q <= 12'h000;
            off_cnt_q <= 12'h000;
            rst_cnt_q <= 12'h000;
            rstn_q <= 1'b1;
            fp_q <= 1'b0;
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            st_q <= tfi_pkg::ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            row_q <= 5'h00;
            lohi_q <= 1'b0;
            second_q <= 1'b0;
            wbuf_q <= 16'h0000;
            wcnt_q <= 2'h0;
            oe_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            mact_q <= 1'b0;
            manch_q <= 1'b0;
            mbit_q <= 1'b0;
            enc_q <= 1'b0;
            hcnt_q <= 12'h000;
            hrun_q <= 1'b0;
            damp_q <= 1'b0;
            emax_q <= 1'b0;
        end else begin
            sup_q <= sup_d;
            auto_q <= auto_d;
            on_cnt_q <= on_cnt_d;
            off_cnt_q <= off_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            rstn_q <= rstn_d;
            fp_q <= fp_d;
            // recovered field clock, two stages against metastability
            clk_s1_q <= carrier_in;
            clk_s2_q <= clk_s1_q;
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            row_q <= row_d;
            lohi_q <= lohi_d;
            second_q <= second_d;
            wbuf_q <= wbuf_d;
            wcnt_q <= wcnt_d;
            oe_q <= oe_d;
            scl_q <= twi_in.scl;
            sda_q <= twi_in.sda;
            mact_q <= mact_d;
            manch_q <= manch_d;
            mbit_q <= mbit_d;
            enc_q <= enc_d;
            hcnt_q <= hcnt_d;
            hrun_q <= hrun_d;
            damp_q <= damp_d;
            emax_q <= emax_d;
        end
    end

    // output mapping; sda is open drain so its data bit is always low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign damping_on = damp_q;
    assign energy_max = emax_q;
    assign field_present_output = fp_q; // gaps are decoded by the host
    assign field_clk_out = clk_s2_q;
    assign supply_field = sup_q;
    assign host_reset_n = rstn_q;
    assign modulator_active = mact_q;

endmodule
`default_nettype wire

/* dv/tfi_ctrl_monitor.sv */
// checker for the transponder field interface controller, ports only
// assumes a bind into tfi_ctrl, one clock sys_clk and reset resetn
`timescale 1ns/10ps
`default_nettype none
module tfi_ctrl_mon #(
    parameter int BFS_CYC = 4,
    parameter int FOFF_CYC = 3,
    parameter int RST_CYC = 3,
    parameter int HALF_CYC = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic field_detect,
    input wire logic carrier_in,
    input wire logic damping_control_input,
    input wire tfi_pkg::tfi_twi_t twi_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic damping_on,
    input wire logic energy_max,
    input wire logic field_present_output,
    input wire logic field_clk_out,
    input wire logic supply_field,
    input wire logic host_reset_n,
    input wire logic modulator_active
);
    // runs of field high, field low and host reset low, in samples
    int fh_q, fh_d, fl_q, fl_d, rl_q, rl_d;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // run counters saturate so a long idle spell never wraps them
    always_comb begin
        fh_d = !field_detect ? 0 : (fh_q < 4096 ? fh_q + 1 : fh_q);
        fl_d = field_detect ? 0 : (fl_q < 4096 ? fl_q + 1 : fl_q);
        rl_d = host_reset_n ? 0 : (rl_q < 4096 ? rl_q + 1 : rl_q);
    end

    // registers only; cleared with the block
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fh_q <= 0;
            fl_q <= 0;
            rl_q <= 0;
        end else begin
            fh_q <= fh_d;
            fl_q <= fl_d;
            rl_q <= rl_d;
        end
    end

    // loss of field supply is the first step of the host reset pulse
    sequence s_field_lost;
        $fell(supply_field) && !$past(field_detect);
    endsequence

    a_supply_rise_delay: assert property (
        $rose(supply_field) |-> fh_q >= BFS_CYC)
        else $error("field supply taken too early");
    a_supply_fall_delay: assert property (
        s_field_lost |-> fl_q >= FOFF_CYC)
        else $error("battery taken back too early");
    a_wake_on_switch: assert property (
        $rose(supply_field) |-> field_present_output)
        else $error("no wake edge at supply switch");
    a_present_low_gap: assert property (
        !field_detect |=> !field_present_output)
        else $error("field output high during gap");
    a_reset_on_loss: assert property (
        s_field_lost |-> !host_reset_n)
        else $error("no host reset at field loss");
    a_reset_pulse_width: assert property (
        $rose(host_reset_n) |-> rl_q == RST_CYC)
        else $error("host reset pulse has wrong width");
    a_damp_follow_pin: assert property (
        (!modulator_active ##1 !modulator_active)
        |-> damping_on == $past(damping_control_input))
        else $error("damping stage not following pin");
    a_energy_max_damp: assert property (
        (damping_control_input && supply_field) [*2] |-> energy_max)
        else $error("maximum energy not routed");
    a_clock_from_carrier: assert property (
        field_clk_out == $past(carrier_in, 2))
        else $error("field clock not carrier");
    a_ack_after_fall: assert property (
        $rose(sda_oe) |-> !$past(twi_in.scl) && !sda_out)
        else $error("data line pulled while clock high");
endmodule
bind tfi_ctrl tfi_ctrl_mon #(
    .BFS_CYC(BFS_CYC),
    .FOFF_CYC(FOFF_CYC),
    .RST_CYC(RST_CYC),
    .HALF_CYC(HALF_CYC)
) u_mon (.*);
`default_nettype wire

/* dv/tfi_host_model.sv */
// host side model: open-drain serial lines with pull-up, damping pin and
// a gap counter; assumes the bench gives line levels, 1 = released
`timescale 1ns/10ps
`default_nettype none
module tfi_host_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic damp_req,
    input wire logic scl_drv,
    input wire logic sda_drv,
    input wire logic sda_oe,
    input wire logic field_present_output,
    output var tfi_pkg::tfi_twi_t twi_in,
    output logic damping_control_input,
    output logic [7:0] gap_count
);
    // previous field level and gap tally
    logic fp_q, fp_d;
    logic [7:0] gap_q, gap_d;

    // pin held high in reset for the best start-up charge
    assign damping_control_input = !resetn | damp_req;
    // wired-and: the pull-up wins unless someone pulls low
    assign twi_in = {scl_drv, sda_drv & !sda_oe};
    assign gap_count = gap_q;

    // demodulation stand-in: each fall of the field output is one gap
    always_comb begin
        fp_d = field_present_output;
        gap_d = gap_q + {7'h00, fp_q & !field_present_output};
    end

    // registers only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fp_q <= 1'h0;
            gap_q <= 8'h00;
        end else begin
            fp_q <= fp_d;
            gap_q <= gap_d;
        end
    end
endmodule
`default_nettype wire

/* dv/tfi_ctrl_tb.sv */
// self-checking bench for tfi_ctrl with shortened timing parameters
// assumes the host model resolves the serial lines and the damping pin
`timescale 1ns/10ps
`default_nettype none
module tfi_ctrl_tb;
    localparam int BFS = 4;
    localparam int FOFF = 3;
    localparam int RSTC = 3;
    localparam int HALF = 4;
    logic sys_clk = 1'h0;
    logic resetn, field_detect, damp_req, scl_drv, sda_drv;
    logic carrier_in = 1'h0;
    logic sda_out, sda_oe, damping_on, energy_max, field_present_output;
    logic field_clk_out, supply_field, host_reset_n, modulator_active;
    logic damping_control_input, a;
    logic [7:0] gap_count, rx;
    tfi_pkg::tfi_twi_t twi_in;
    int bad_count = 0;
    int comparisons = 0;

    always #20 sys_clk = ~sys_clk;
    // carrier runs only out of reset so the clock path starts clean
    always @(negedge sys_clk) if (resetn) carrier_in <= ~carrier_in;

    tfi_host_model u_host (.sys_clk(sys_clk), .resetn(resetn),
        .damp_req(damp_req), .scl_drv(scl_drv), .sda_drv(sda_drv),
        .sda_oe(sda_oe), .field_present_output(field_present_output),
        .twi_in(twi_in), .damping_control_input(damping_control_input),
        .gap_count(gap_count));
    tfi_ctrl #(.BFS_CYC(BFS), .FOFF_CYC(FOFF), .RST_CYC(RSTC),
        .HALF_CYC(HALF)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .field_detect(field_detect), .carrier_in(carrier_in),
        .damping_control_input(damping_control_input), .twi_in(twi_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .damping_on(damping_on),
        .energy_max(energy_max),
        .field_present_output(field_present_output),
        .field_clk_out(field_clk_out), .supply_field(supply_field),
        .host_reset_n(host_reset_n), .modulator_active(modulator_active));

    // compare and tally
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // serial line tasks; all changes land on falling clock edges
    task automatic tw_start;
        scl_drv = 1'h1;
        sda_drv = 1'h1;
        cyc(3);
        sda_drv = 1'h0;
        cyc(3);
        scl_drv = 1'h0;
        cyc(2);
    endtask
    task automatic tw_stop;
        sda_drv = 1'h0;
        cyc(2);
        scl_drv = 1'h1;
        cyc(3);
        sda_drv = 1'h1;
        cyc(3);
    endtask
    task automatic tw_bit(input logic b, output logic r);
        sda_drv = b;
        cyc(3);
        scl_drv = 1'h1;
        cyc(3);
        r = twi_in.sda;
        scl_drv = 1'h0;
        cyc(1);
    endtask
    // one byte both ways, then the acknowledge slot
    task automatic tw_byte(input logic [7:0] tx, input logic ai,
        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) tw_bit(tx[i], r[i]);
        tw_bit(ai, ack);
    endtask
    task automatic tw_cmd(input logic [4:0] row, input logic [1:0] mode,
        input logic rnw, output logic ack);
        logic [7:0] r;
        tw_start;
        tw_byte({row, mode, rnw}, 1'h1, r, ack);
        chk(ack, 1'h0);
    endtask
    // coded bits 1,0,0,1, spaced well past two half bits
    task automatic mod_run(input logic [4:0] cmd);
        logic [3:0] pat;
        logic d0, k;
        pat = 4'h9;
        tw_cmd(cmd, tfi_pkg::MODE_SPECIAL, 1'h0, k);
        cyc(2);
        chk(modulator_active, 1'h1);
        for (int i = 0; i < 4; i++) begin
            sda_drv = pat[i];
            cyc(4);
            scl_drv = 1'h1;
            cyc(3);
            d0 = damping_on;
            cyc(4);
            if (cmd == tfi_pkg::CMD_MOD_MANCH) begin
                chk(d0, pat[i]);
                chk(damping_on, !pat[i]);
            end else begin
                chk(d0 ^ damping_on, !pat[i]);
            end
            scl_drv = 1'h0;
            cyc(1);
        end
        tw_stop;
        chk(modulator_active, 1'h0);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog well beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_of_test;
    end

    initial begin
        resetn = 1'h0;
        field_detect = 1'h0;
        damp_req = 1'h0;
        scl_drv = 1'h1;
        sda_drv = 1'h1;
        cyc(12);
        resetn = 1'h1;
        cyc(2);
        chk(damping_on, 1'h0);
        damp_req = 1'h1;
        cyc(2);
        chk(damping_on, 1'h1);
        // field arrives; switch only after the filter delay
        field_detect = 1'h1;
        // BFS samples of field are needed; one short of that, still battery
        cyc(BFS - 1);
        chk(supply_field, 1'h0);
        cyc(3);
        chk(supply_field, 1'h1);
        chk(field_present_output, 1'h1);
        chk(energy_max, 1'h1);
        // one-cycle gap: output drops, supply holds
        field_detect = 1'h0;
        cyc(1);
        chk(field_present_output, 1'h0);
        field_detect = 1'h1;
        cyc(2);
        chk(supply_field, 1'h1);
        chk(gap_count, 8'h01);
        // field removed: battery back and a host reset pulse
        field_detect = 1'h0;
        cyc(FOFF + 1);
        chk(supply_field, 1'h0);
        chk(host_reset_n, 1'h0);
        cyc(RSTC + 1);
        chk(host_reset_n, 1'h1);
        // field clock trails the carrier by two edges, then tracks it
        a = carrier_in;
        cyc(1);
        chk(field_clk_out, a);
        cyc(1);
        chk(field_clk_out, !a);
        chk(sda_out, 1'h0);
        // automatic switching off, then back on
        tw_cmd(tfi_pkg::CMD_PM_OFF, tfi_pkg::MODE_SPECIAL, 1'h0, a);
        tw_stop;
        field_detect = 1'h1;
        cyc(BFS + 4);
        chk(supply_field, 1'h0);
        tw_cmd(tfi_pkg::CMD_PM_ON, tfi_pkg::MODE_SPECIAL, 1'h0, a);
        tw_stop;
        cyc(BFS + 4);
        chk(supply_field, 1'h1);
        field_detect = 1'h0;
        cyc(FOFF + RSTC + 6);
        // store: high-then-low write, third byte refused
        tw_cmd(5'h05, tfi_pkg::MODE_HI_LO, 1'h0, a);
        tw_byte(8'hA5, 1'h1, rx, a);
        chk(a, 1'h0);
        tw_byte(8'h3C, 1'h1, rx, a);
        chk(a, 1'h0);
        tw_byte(8'h77, 1'h1, rx, a);
        chk(a, 1'h1);
        tw_stop;
        // read back low byte first, ended by a not-acknowledge
        tw_cmd(5'h05, tfi_pkg::MODE_LO_HI, 1'h1, a);
        tw_byte(8'hFF, 1'h0, rx, a);
        chk(rx, 8'h3C);
        tw_byte(8'hFF, 1'h1, rx, a);
        chk(rx, 8'hA5);
        tw_stop;
        // both coders, pin held high to show the override
        mod_run(tfi_pkg::CMD_MOD_MANCH);
        mod_run(tfi_pkg::CMD_MOD_BIPH);
        cyc(2);
        chk(damping_on, 1'h1);
        end_of_test;
    end
endmodule
`default_nettype wire
